//--- verilog/sli_status_led.sv
// Front-panel status indicator logic with AHB-Lite register slave
`timescale 1ns/100ps

// Register map, one aligned word each, unused bits read zero
//   0x00 control: bit 0 lamp test, forces all five LEDs on
//   0x04 status, read only:
//        bit 0 application ready level
//        bit 1 application running level
//        bit 2 recovery in progress level
//        bit 3 hardware fault level
//        bit 4 address conflict level
//        bit 5 ethernet link level
//        bits 12:8 the registered LED drive word
//   0x08 sticky event status, write one to clear:
//        bit 0 qualified serial message
//        bit 1 qualified mesh command
//        bit 2 qualified ethernet frame
//        bit 3 link change, either direction
//        bit 4 address conflict appears
//        bit 5 hardware fault appears
//   0x0c interrupt mask, same layout, one enables
//   0x10 flash on-time in milliseconds, zero stores one
// Any other address reads zero and ignores writes.
//
// Bus timing
//   Zero wait states: the slave is ready in every cycle.
//   Read data is captured at the address phase edge,
//   so it stands for the whole following data phase.
//   Writes land at the edge that closes the data phase;
//   a read whose address phase overlaps that data phase still sees the old value.
//   Transfer size is not decoded; masters use words.
//
// Pattern timing
//   A prescaler makes a one-cycle millisecond enable.
//   A free-running counter wraps every 1000 ms and
//   all blink patterns are decoded from that one count,
//   so power and fault blinking stay in phase.
//   Slow blink: on for ms 0-249 and 500-749.
//   Conflict blink: on for the first 500 ms of a second.
//   The counter is never restarted by a level change,
//   so the first blink after a change may be shortened.
//
// Activity flashes
//   Each qualified message reloads a per-channel counter
//   with the programmed on-time; the counter then falls
//   by one per millisecond enable.  Because the enable is
//   free running the seen on-time lies between the value
//   minus one and the value in milliseconds.
//   A burst of messages keeps the LED lit, which is the
//   intent: an operator cannot resolve faster flashes.
//   Ethernet activity is shown as a dark gap in the steady
//   link light, since the link light is normally on.
//
// Interrupts
//   Status bits are sticky; an event in the same cycle as
//   a clear wins, so no event is ever lost to software.
//   The interrupt line is the OR of the status bits ANDed with the mask,
//   registered from their next values, so it changes at the same edge as they do.
//
// Lamp test
//   Overrides every pattern but leaves the internal
//   counters running, so patterns resume in phase.

// Summary of operation
// - Valid serial message gives short flash
// - Foreign or errored serial message stays dark
// - Serial LED off without traffic
// - Power LED steady when fully ready
// - Power LED flashes while app not ready
// - Power LED off when not running
// - Valid mesh message gives short flash
// - Mesh commands flash, bursts and events not
// - Mesh LED off without traffic
// - Fault LED steady on fault, else off
// - Fault LED flashes during recovery
// - Ethernet LED steady while link up
// - Ethernet LED pulses once per message
// - No pulse for foreign or errored frames
// - Address conflict flashes once per second
// - Ethernet LED off without link
module sli_status_led #(
	parameter int unsigned MS_CYC = sli_pkg::MS_CYCLES
) (
	input  wire logic              core_clk_i,
	input  wire logic              reset_i,
	input  wire sli_pkg::sli_evt_t evt_i,
	input  wire sli_pkg::sli_lvl_t lvl_i,
	output sli_pkg::sli_led_t      led_o,
	output logic                   irq_o,
	input  wire logic              hsel_i,
	input  wire logic [31:0]       haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [31:0]       hwdata_i,
	input  wire logic              hready_i,
	output logic [31:0]            hrdata_o,
	output logic                   hreadyout_o,
	output logic                   hresp_o
);
	import sli_pkg::*;

	// Whole block state in one record
	typedef struct packed {
		logic [23:0]             ms_pre;
		logic [9:0]              ms_cnt;
		logic [ACT_N-1:0][15:0]  act_cnt;
		logic [15:0]             pulse_ms;
		logic                    lamp;
		logic [IRQ_W-1:0]        ists;
		logic [IRQ_W-1:0]        imsk;
		logic                    link_q;
		logic                    confl_q;
		logic                    fault_q;
		logic                    dp_act;
		logic                    dp_write;
		logic [4:0]              dp_addr;
		logic [31:0]             rdata;
		logic                    rdy;
		logic                    resp;
		logic                    irq;
		sli_led_t                led;
	} sli_state_t;

	sli_state_t st_reg;
	sli_state_t st_next;

	logic                    ms_tick;
	logic                    slow_on;
	logic                    confl_on;
	logic [ACT_N-1:0]        act_hit;
	logic [ACT_N-1:0]        act_on;
	logic [IRQ_W-1:0]        irq_set;
	logic [IRQ_W-1:0]        irq_clr;
	logic                    addr_ok;
	logic [31:0]             rd_val;
	logic                    pwr_led;
	logic                    fault_led;
	logic                    eth_led;

	// Millisecond enable from the system clock
	assign ms_tick = (st_reg.ms_pre == 24'(MS_CYC - 1));

	// Square waves: half-second slow blink and one-second conflict blink
	assign slow_on  = (st_reg.ms_cnt < 10'(SLOW_HALF_MS))
		|| ((st_reg.ms_cnt >= 10'(2 * SLOW_HALF_MS))
		&& (st_reg.ms_cnt < 10'(3 * SLOW_HALF_MS)));
	assign confl_on = (st_reg.ms_cnt < 10'(CONFL_ON_MS));

	// Qualify the receive events before they may start a flash
	assign act_hit[ACT_RS]   = evt_i.rs_msg && evt_i.rs_for_me && !evt_i.rs_err;
	assign act_hit[ACT_MESH] = evt_i.mesh_msg && !evt_i.mesh_err
		&& (evt_i.mesh_kind == MESH_CMD);
	assign act_hit[ACT_ETH]  = evt_i.eth_msg && evt_i.eth_for_me
		&& !evt_i.eth_err && lvl_i.eth_link;

	// One stretcher per activity channel
	genvar gi;
	generate
		for (gi = 0; gi < ACT_N; gi++) begin : g_act
			assign act_on[gi] = (st_reg.act_cnt[gi] != 16'h0000);
		end
	endgenerate

	// Power: off, flashing while starting, steady once ready
	always_comb begin
		if (!lvl_i.app_run) begin
			pwr_led = 1'b0;
		end else if (!lvl_i.app_ready) begin
			pwr_led = slow_on;
		end else begin
			pwr_led = 1'b1;
		end
	end

	// Fault: recovery blinking has precedence over the steady fault
	always_comb begin
		if (lvl_i.hw_recover) begin
			fault_led = slow_on;
		end else begin
			fault_led = lvl_i.hw_fault;
		end
	end

	// Ethernet: activity shows as a dark gap in the steady link light
	always_comb begin
		if (!lvl_i.eth_link) begin
			eth_led = 1'b0;
		end else if (lvl_i.ip_conflict) begin
			eth_led = confl_on;
		end else if (act_on[ACT_ETH]) begin
			eth_led = 1'b0;
		end else begin
			eth_led = 1'b1;
		end
	end

	// Interrupt sources: messages plus edges of link, conflict and fault
	always_comb begin
		irq_set            = '0;
		irq_set[IRQ_RS]    = act_hit[ACT_RS];
		irq_set[IRQ_MESH]  = act_hit[ACT_MESH];
		irq_set[IRQ_ETH]   = act_hit[ACT_ETH];
		irq_set[IRQ_LINK]  = lvl_i.eth_link != st_reg.link_q;
		irq_set[IRQ_CONFL] = lvl_i.ip_conflict && !st_reg.confl_q;
		irq_set[IRQ_FAULT] = lvl_i.hw_fault && !st_reg.fault_q;
	end

	// Address decode of the captured data phase
	assign addr_ok = (st_reg.dp_addr <= REG_PULSE);

	// Read mux; unmapped words read as zero
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (haddr_i[4:0])
			REG_CTRL: begin
				rd_val[CTRL_LAMP_BIT] = st_reg.lamp;
			end
			REG_STAT: begin
				// Live levels, no history kept
				rd_val[0] = lvl_i.app_ready;
				rd_val[1] = lvl_i.app_run;
				rd_val[2] = lvl_i.hw_recover;
				rd_val[3] = lvl_i.hw_fault;
				rd_val[4] = lvl_i.ip_conflict;
				rd_val[5] = lvl_i.eth_link;
				rd_val[STAT_LED_LSB +: 5] = st_reg.led;
			end
			REG_ISTS: begin
				rd_val[IRQ_W-1:0] = st_reg.ists;
			end
			REG_IMSK: begin
				rd_val[IRQ_W-1:0] = st_reg.imsk;
			end
			REG_PULSE: begin
				rd_val[15:0] = st_reg.pulse_ms;
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
		if (haddr_i[31:5] != 27'h0) begin
			rd_val = 32'h0000_0000;
		end
	end

	// Write-one-to-clear strobe for the sticky status
	always_comb begin
		irq_clr = '0;
		if (st_reg.dp_act && st_reg.dp_write && (st_reg.dp_addr == REG_ISTS)) begin
			irq_clr = hwdata_i[IRQ_W-1:0];
		end
	end

	// Next-state logic for the whole block
	always_comb begin
		st_next = st_reg;

		// Prescaler and one-second pattern counter
		if (ms_tick) begin
			st_next.ms_pre = 24'h00_0000;
			if (st_reg.ms_cnt == 10'(FLASH_PERIOD_MS - 1)) begin
				st_next.ms_cnt = 10'h000;
			end else begin
				st_next.ms_cnt = st_reg.ms_cnt + 10'h001;
			end
		end else begin
			st_next.ms_pre = st_reg.ms_pre + 24'h00_0001;
		end

		// Retrigger on a hit, else count the on-time down per millisecond
		for (int i = 0; i < ACT_N; i++) begin
			if (act_hit[i]) begin
				st_next.act_cnt[i] = st_reg.pulse_ms;
			end else if (ms_tick && act_on[i]) begin
				st_next.act_cnt[i] = st_reg.act_cnt[i] - 16'h0001;
			end
		end

		// Edge history for the level interrupt sources
		st_next.link_q  = lvl_i.eth_link;
		st_next.confl_q = lvl_i.ip_conflict;
		st_next.fault_q = lvl_i.hw_fault;

		// A new event outweighs a clear in the same cycle
		st_next.ists = (st_reg.ists & ~irq_clr) | irq_set;
		st_next.irq  = |(st_next.ists & st_reg.imsk);

		// Register writes land in the data phase
		if (st_reg.dp_act && st_reg.dp_write && addr_ok) begin
			unique case (st_reg.dp_addr)
				REG_CTRL: begin
					st_next.lamp = hwdata_i[CTRL_LAMP_BIT];
				end
				REG_IMSK: begin
					st_next.imsk = hwdata_i[IRQ_W-1:0];
					st_next.irq  = |(st_next.ists & hwdata_i[IRQ_W-1:0]);
				end
				REG_PULSE: begin
					// Zero would hide every flash, so one ms is the floor
					if (hwdata_i[15:0] == 16'h0000) begin
						st_next.pulse_ms = 16'h0001;
					end else begin
						st_next.pulse_ms = hwdata_i[15:0];
					end
				end
				default: begin
					st_next.lamp = st_reg.lamp;
				end
			endcase
		end

		// Address phase capture; zero wait states, always OKAY
		st_next.rdy    = 1'b1;
		st_next.resp   = 1'b0;
		st_next.dp_act = 1'b0;
		if (hready_i) begin
			st_next.dp_act   = hsel_i && htrans_i[1];
			st_next.dp_write = hwrite_i;
			st_next.dp_addr  = (haddr_i[31:5] == 27'h0) ? haddr_i[4:0] : 5'h1f;
			if (hsel_i && htrans_i[1] && !hwrite_i) begin
				st_next.rdata = rd_val;
			end
		end

		// Output patterns; lamp test lights all five at once
		st_next.led.rs    = act_on[ACT_RS];
		st_next.led.mesh  = act_on[ACT_MESH];
		st_next.led.pwr   = pwr_led;
		st_next.led.fault = fault_led;
		st_next.led.eth   = eth_led;
		if (st_reg.lamp) begin
			st_next.led = '1;
		end
	end

	// State register with synchronous reset
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_reg          <= '0;
			st_reg.pulse_ms <= PULSE_MS_RST;
			st_reg.rdy      <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Every output straight from the state flops
	assign led_o       = st_reg.led;
	assign irq_o       = st_reg.irq;
	assign hrdata_o    = st_reg.rdata;
	assign hreadyout_o = st_reg.rdy;
	assign hresp_o     = st_reg.resp;

	// Transfer size is word-only by contract
	logic unused_size;
	assign unused_size = ^hsize_i;

endmodule : sli_status_led

//--- verilog/sli_pkg.sv
// Package for the status indicator block: register map, fields, timing, carriers
package sli_pkg;

	// Clock rate and derived millisecond prescale
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;

	// Pattern timing in milliseconds
	localparam int unsigned FLASH_PERIOD_MS = 1000;
	localparam int unsigned CONFL_ON_MS     = FLASH_PERIOD_MS / 2;
	localparam int unsigned SLOW_HALF_MS    = 250;
	localparam logic [15:0] PULSE_MS_RST    = 16'h0032;

	// Register byte offsets
	localparam logic [4:0] REG_CTRL  = 5'h00;
	localparam logic [4:0] REG_STAT  = 5'h04;
	localparam logic [4:0] REG_ISTS  = 5'h08;
	localparam logic [4:0] REG_IMSK  = 5'h0c;
	localparam logic [4:0] REG_PULSE = 5'h10;

	// Field positions
	localparam int CTRL_LAMP_BIT = 0;
	localparam int STAT_LED_LSB  = 8;
	localparam int IRQ_W         = 6;
	localparam int IRQ_RS        = 0;
	localparam int IRQ_MESH      = 1;
	localparam int IRQ_ETH       = 2;
	localparam int IRQ_LINK      = 3;
	localparam int IRQ_CONFL     = 4;
	localparam int IRQ_FAULT     = 5;

	// Activity channels
	localparam int ACT_N    = 3;
	localparam int ACT_RS   = 0;
	localparam int ACT_MESH = 1;
	localparam int ACT_ETH  = 2;

	// Kind of a received mesh message
	typedef enum logic [1:0] {
		MESH_CMD,
		MESH_BURST,
		MESH_EVENT,
		MESH_OTHER
	} sli_mesh_kind_t;

	// Receive events, one-cycle pulses with qualifiers
	typedef struct packed {
		logic           rs_msg;
		logic           rs_for_me;
		logic           rs_err;
		logic           mesh_msg;
		sli_mesh_kind_t mesh_kind;
		logic           mesh_err;
		logic           eth_msg;
		logic           eth_for_me;
		logic           eth_err;
	} sli_evt_t;

	// Steady status levels
	typedef struct packed {
		logic eth_link;
		logic ip_conflict;
		logic hw_fault;
		logic hw_recover;
		logic app_run;
		logic app_ready;
	} sli_lvl_t;

	// LED drive levels, high lights the LED
	typedef struct packed {
		logic eth;
		logic fault;
		logic mesh;
		logic pwr;
		logic rs;
	} sli_led_t;

endpackage : sli_pkg

//--- tb/sli_led_view.sv
// Operator model of the panel: counts flashes and lit cycles per LED
`timescale 1ns/100ps
module sli_led_view (
	input wire logic              core_clk_i,
	input wire logic              clr_i,
	input wire sli_pkg::sli_led_t led_i
);
	import sli_pkg::*;
	int         rise [5];
	int         lit [5];
	logic [4:0] prev = '0;
	// An eye sees levels only; counts restart on clear
	always @(posedge core_clk_i) begin
		prev <= led_i;
		for (int i = 0; i < 5; i++) begin
			rise[i] <= clr_i ? 0 : rise[i] + int'(led_i[i] & ~prev[i]);
			lit[i] <= clr_i ? 0 : lit[i] + int'(led_i[i]);
		end
	end
endmodule : sli_led_view

//--- tb/sli_status_led_chk.sv
// Concurrent checks on the status indicator outputs
`timescale 1ns/100ps
module sli_status_led_chk (
	input wire logic              core_clk_i,
	input wire logic              reset_i,
	input wire sli_pkg::sli_evt_t evt_i,
	input wire sli_pkg::sli_lvl_t lvl_i,
	input wire sli_pkg::sli_led_t led_o,
	input wire logic              hsel_i,
	input wire logic [31:0]       haddr_i,
	input wire logic [1:0]        htrans_i,
	input wire logic              hwrite_i,
	input wire logic [31:0]       hwdata_i,
	input wire logic              hready_i
);
	import sli_pkg::*;
	logic ctl_wr, lamp, lamp_d, lamp_q;
	wire  rs_hit   = evt_i.rs_msg && evt_i.rs_for_me && !evt_i.rs_err;
	wire  mesh_hit = evt_i.mesh_msg && evt_i.mesh_kind == MESH_CMD && !evt_i.mesh_err;
	wire  eth_hit  = evt_i.eth_msg && evt_i.eth_for_me && !evt_i.eth_err;
	wire  eth_calm = lvl_i.eth_link && !lvl_i.ip_conflict;
	// Lamp test forces all LEDs on, so checks pause while it acts
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			{ctl_wr, lamp, lamp_d, lamp_q} <= '0;
		end else begin
			ctl_wr <= hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i == 32'h0;
			if (ctl_wr) lamp <= hwdata_i[0];
			lamp_d <= lamp;
			lamp_q <= lamp_d;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i || lamp || lamp_d || lamp_q);
	a_rs_flash: assert property (rs_hit |-> ##2 led_o.rs)
		else $error("serial LED missed a flash");
	a_rs_cause: assert property ($rose(led_o.rs) |-> $past(rs_hit, 2))
		else $error("serial LED lit without valid message");
	a_mesh_flash: assert property (mesh_hit |-> ##2 led_o.mesh)
		else $error("mesh LED missed a flash");
	a_mesh_cause: assert property ($rose(led_o.mesh) |-> $past(mesh_hit, 2))
		else $error("mesh LED lit without command message");
	a_pwr_on: assert property (lvl_i.app_run && lvl_i.app_ready |=> led_o.pwr)
		else $error("power LED not steady when ready");
	a_pwr_off: assert property (!lvl_i.app_run |=> !led_o.pwr)
		else $error("power LED lit while not running");
	a_fault_on: assert property (lvl_i.hw_fault && !lvl_i.hw_recover |=> led_o.fault)
		else $error("fault LED dark during fault");
	a_fault_off: assert property (!lvl_i.hw_fault && !lvl_i.hw_recover |=> !led_o.fault)
		else $error("fault LED lit without fault");
	a_eth_gap: assert property (eth_hit && eth_calm ##1 eth_calm |=> !led_o.eth)
		else $error("ethernet LED did not pulse");
	a_eth_nolink: assert property (!lvl_i.eth_link |=> !led_o.eth)
		else $error("ethernet LED lit without link");
	c_rs_hit: cover property (rs_hit ##2 led_o.rs);
	c_eth_gap: cover property (eth_hit && eth_calm);
	c_fault_blink: cover property (lvl_i.hw_recover && $rose(led_o.fault));
endmodule : sli_status_led_chk
bind sli_status_led sli_status_led_chk u_chk (.core_clk_i, .reset_i, .evt_i, .lvl_i, .led_o,
	.hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i);

//--- tb/tb.sv
// Self-checking bench for the status indicator block
`timescale 1ns/100ps
module tb;
	import sli_pkg::*;
	logic        core_clk_i = 0, reset_i = 1, hsel = 0, hwrite = 0, clr = 0, irq, hrdy, hresp;
	logic [1:0]  htrans = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	sli_evt_t    evt = '0;
	sli_lvl_t    lvl = '0;
	sli_led_t    led;
	int          fails = 0, n_tests = 0;
	// Short ms tick keeps blink periods to 10000 cycles
	always #50 core_clk_i = ~core_clk_i;
	sli_status_led #(.MS_CYC(10)) uut (.core_clk_i, .reset_i, .evt_i(evt), .lvl_i(lvl),
		.led_o(led), .irq_o(irq), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp));
	sli_led_view view (.core_clk_i, .clr_i(clr), .led_i(led));
	task wrap_up;
		if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task check(input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Bounded wait for hready at a rising edge
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge core_clk_i);
			i++;
		end while (hrdy !== 1'b1 && i < 20);
		if (i >= 20) begin
			fails++;
			wrap_up();
		end
	endtask : wait_rdy
	task bus(input logic w, input logic [31:0] a, d);
		@(posedge core_clk_i);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask : bus
	task win(input int n);
		@(posedge core_clk_i);
		clr <= 1'b1;
		@(posedge core_clk_i);
		clr <= 1'b0;
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : win
	// One event, then 29 cycles watched; f picks serial, mesh or ethernet
	task act(input int f, input sli_mesh_kind_t k, input logic me, er, input int idx, exp);
		sli_evt_t e;
		e = '0;
		if (f == 0) {e.rs_msg, e.rs_for_me, e.rs_err} = {1'b1, me, er};
		else if (f == 1) {e.mesh_msg, e.mesh_kind, e.mesh_err} = {1'b1, k, er};
		else {e.eth_msg, e.eth_for_me, e.eth_err} = {1'b1, me, er};
		@(posedge core_clk_i);
		clr <= 1'b1;
		evt <= e;
		@(posedge core_clk_i);
		clr <= 1'b0;
		evt <= '0;
		repeat (29) @(posedge core_clk_i);
		#1;
		check(view.rise[idx], exp);
		if (exp && idx != 4) check(view.lit[idx] inside {[9:21]}, 1'b1);
		if (!exp) check(view.lit[idx], idx == 4 ? 29 : 0);
	endtask : act
	initial begin
		repeat (8) @(posedge core_clk_i);
		reset_i <= 1'b0;
		win(2);
		check(led, 5'h0);
		bus(0, 32'h10, 0);
		check(q, 32'h32);
		bus(1, 32'h10, 0);
		bus(0, 32'h10, 0);
		check(q, 32'h1);
		bus(1, 32'h10, 2);
		bus(0, 32'h14, 0);
		check(q, 32'h0);
		bus(1, 32'h0c, 32'h1);
		act(0, MESH_CMD, 1, 0, 0, 1);
		check(irq, 1'b1);
		bus(1, 32'h08, 32'h3f);
		win(1);
		check(irq, 1'b0);
		act(0, MESH_CMD, 0, 0, 0, 0);
		act(0, MESH_CMD, 1, 1, 0, 0);
		act(1, MESH_CMD, 1, 0, 2, 1);
		act(1, MESH_BURST, 1, 0, 2, 0);
		act(1, MESH_EVENT, 1, 0, 2, 0);
		act(1, MESH_OTHER, 1, 0, 2, 0);
		act(1, MESH_CMD, 1, 1, 2, 0);
		bus(1, 32'h0c, 32'h0);
		act(0, MESH_CMD, 1, 0, 0, 1);
		check(irq, 1'b0);
		bus(0, 32'h08, 0);
		check(q[0], 1'b1);
		// Steady levels first, then all three blink patterns together
		lvl <= '{eth_link: 1'b1, hw_fault: 1'b1, app_run: 1'b1, app_ready: 1'b1, default: 1'b0};
		win(3);
		check({led.eth, led.fault, led.pwr}, 3'h7);
		act(2, MESH_CMD, 1, 0, 4, 1);
		act(2, MESH_CMD, 0, 0, 4, 0);
		act(2, MESH_CMD, 1, 1, 4, 0);
		lvl <= '{eth_link: 1'b1, ip_conflict: 1'b1, hw_recover: 1'b1, app_run: 1'b1,
			default: 1'b0};
		win(3);
		win(10000);
		check(view.lit[1], 32'd5000);
		check(view.rise[1], 32'd2);
		check(view.lit[3], 32'd5000);
		check(view.rise[3], 32'd2);
		check(view.lit[4], 32'd5000);
		check(view.rise[4], 32'd1);
		lvl <= '{ip_conflict: 1'b1, default: 1'b0};
		win(3);
		win(3000);
		check(view.lit[1], 32'h0);
		check(view.lit[3], 32'h0);
		check(view.lit[4], 32'h0);
		check(hresp, 1'b0);
		wrap_up();
	end
endmodule : tb
